// >>> shared/pss_pkg.sv
// Purpose: shared constants and types for power sequencing ends
// Assumes: pclk runs at 10 MHz on both ends
// Notes: comparator inputs arrive raw from the analog side
// Function
// - Pump stops at regulation, resumes after hysteresis drop
// - Pump off in shutdown, measurement, manual disable
// - Pump undervoltage sets first diagnostic bit 3
// - Low headroom during acquisition sets second bit 2
// - Pump overvoltage disables pump, sets second bit 0
// - Fast clock for logic and timers, slow clock only checked
// - Fast count over two slow periods checked
// - Redundant slow oscillator alert mirrors first
// - No fast oscillator alert; comm errors instead
// - 24-bit identity split; zero identity invalid
// - Shutdown low: regulator off, reset held
// - Lower receive activity pumps shutdown input high
// - Reset release, oscillators, pump, then logic
// - Operational within wake time of first traffic
// - Forced reset pulldown discharges shutdown input
// - Host keeps traffic going to stay awake
// - Soft reset clears registers, drops ready back to pump phase
// - Single-ended host drives shutdown input directly
// - Shutdown sets alert, regulator off, later reset
// - Chain at most 32, host starts everything
// - Forward lower to upper; last loops down
// - Host picks one of three rates
// - Rate locked from first preamble after reset
package pss_pkg;
	// Clocks and times
	localparam int CLK_HZ        = 10_000_000;
	localparam int SLOW_HZ       = 32_768;
	localparam int WAKE_TIME_US  = 1000;
	localparam int WAKE_CYC      = WAKE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int PUMP_HOLD_US  = 200;
	localparam int PUMP_HOLD_CYC = PUMP_HOLD_US * (CLK_HZ / 1_000_000);
	localparam int OSC_EXP       = (2 * CLK_HZ) / SLOW_HZ;
	localparam int OSC_TOL_PCT   = 5;
	localparam int OSC_TOL       = (OSC_EXP * OSC_TOL_PCT) / 100;
	// Link rates, bit times in cycles
	localparam int BIT_2M_CYC    = CLK_HZ / 2_000_000;
	localparam int BIT_1M_CYC    = CLK_HZ / 1_000_000;
	localparam int BIT_05M_CYC   = CLK_HZ / 500_000;
	localparam logic [1:0] RATE_2M  = 2'h0;
	localparam logic [1:0] RATE_1M  = 2'h1;
	localparam logic [1:0] RATE_05M = 2'h2;
	localparam int CHAIN_MAX     = 32;
	// Diagnostic word bit positions
	localparam int DS1_HVUV_BIT  = 3;
	localparam int DS1_OSCB_BIT  = 14;
	localparam int DS1_OSCA_BIT  = 15;
	localparam int DS2_HVOV_BIT  = 0;
	localparam int DS2_HDRM_BIT  = 2;
	localparam logic [15:0] DS_RST = 16'h0000;
	// Comparator vector positions
	localparam int CMP_AT_REG    = 0;
	localparam int CMP_LOW_HYST  = 1;
	localparam int CMP_HVUV      = 2;
	localparam int CMP_HVOV      = 3;
	localparam int CMP_HDRM      = 4;
	localparam int CMP_VAA_OK    = 5;
	localparam int CMP_N         = 6;
	// Host register map
	localparam logic [11:0] REG_CTRL  = 12'h000;
	localparam logic [11:0] REG_CHAIN = 12'h004;
	localparam logic [11:0] REG_STAT  = 12'h008;
	localparam int CTRL_TRAFFIC  = 0;
	localparam int CTRL_SD_EN    = 1;
	localparam int CTRL_SD_LVL   = 2;
	localparam int CTRL_RATE     = 3;
	localparam int CTRL_SE       = 5;
	localparam logic [5:0] CTRL_RST  = 6'h00;
	localparam logic [5:0] CHAIN_RST = 6'h01;
	localparam int STAT_IDV      = 16;
	localparam int STAT_SD       = 17;
	// Sequencer states, gray along power-up path
	typedef enum logic [2:0] {
		ST_OFF   = 3'b000,
		ST_REG   = 3'b001,
		ST_OSC   = 3'b011,
		ST_PUMP  = 3'b010,
		ST_READY = 3'b110,
		ST_DRAIN = 3'b111
	} pss_state_t;
endpackage

// >>> shared/pss_link_if.sv
// Purpose: link between host end and device end
// Assumes: shutdown pin pulls low when nobody drives it
// Notes: host drive wins over device drive on shutdown pin
`timescale 1ns/1ns
`default_nettype none
interface pss_link_if;
	logic lower_rx;
	logic lower_tx;
	logic host_sd_out;
	logic host_sd_oe;
	logic dev_sd_out;
	logic dev_sd_oe;
	logic sd_level;

	// Resolved shutdown pin level
	assign sd_level = host_sd_oe ? host_sd_out :
		(dev_sd_oe ? dev_sd_out : 1'b0);

	modport dev (input lower_rx, input sd_level, output lower_tx,
		output dev_sd_out, output dev_sd_oe);
	modport host (output lower_rx, output host_sd_out,
		output host_sd_oe, input lower_tx, input sd_level);
endinterface
`default_nettype wire

// >>> rtl/pss_host.sv
// Purpose: host end, APB controlled traffic and shutdown drive
// Assumes: APB master with 32-bit data
// Notes: zero wait states, unmapped address answers with error
`timescale 1ns/1ns
`default_nettype none
module pss_host
	import pss_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [23:0] ident_value,
	pss_link_if.host         link
);
	logic [5:0]  ctrl_ff;
	logic [5:0]  chain_ff;
	logic [15:0] cnt_ff;
	logic [31:0] rdata_ff;
	logic [4:0]  div_ff;
	logic        tx_ff;
	logic [2:0]  rx_sync_ff;
	logic        rx_stb_ff;
	logic        rx_prev_ff;
	logic [4:0]  half_cyc;
	logic [5:0]  wr_chain;
	logic        setup;
	logic        access;
	logic        hit_ctrl;
	logic        hit_chain;
	logic        hit_stat;
	logic        hit;
	logic        wr;
	logic        rx_edge;
	logic        div_end;
	logic [31:0] rd_mux;

	// Bus decode
	assign setup     = psel & ~penable;
	assign access    = psel & penable;
	assign hit_ctrl  = paddr == REG_CTRL;
	assign hit_chain = paddr == REG_CHAIN;
	assign hit_stat  = paddr == REG_STAT;
	assign hit       = hit_ctrl | hit_chain | hit_stat;
	assign wr        = access & pwrite & hit;
	assign pready    = 1'b1;
	assign pslverr   = access & ~hit;
	assign prdata    = rdata_ff;

	// Read data selection
	assign rd_mux = hit_ctrl ? {26'h0, ctrl_ff} :
		hit_chain ? {26'h0, chain_ff} :
		hit_stat ? {14'h0, link.sd_level, (|ident_value), cnt_ff} :
		32'h0;

	// Chain length clipped to the maximum
	assign wr_chain = (pwdata[6:0] > 7'(CHAIN_MAX)) ?
		6'(CHAIN_MAX) : pwdata[5:0];

	// Rate selects toggle period
	assign half_cyc = (ctrl_ff[CTRL_RATE+:2] == RATE_1M) ?
		5'(BIT_1M_CYC) : (ctrl_ff[CTRL_RATE+:2] == RATE_05M) ?
		5'(BIT_05M_CYC) : 5'(BIT_2M_CYC);
	assign div_end  = div_ff >= half_cyc - 5'h01;
	assign rx_edge  = rx_stb_ff ^ rx_prev_ff;

	// Link outputs
	assign link.lower_rx    = tx_ff;
	assign link.host_sd_out = ctrl_ff[CTRL_SD_LVL];
	assign link.host_sd_oe  = ctrl_ff[CTRL_SD_EN] | ctrl_ff[CTRL_SE];

	// Registers and read capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff  <= CTRL_RST;
			chain_ff <= CHAIN_RST;
			rdata_ff <= 32'h0;
		end else begin
			if (setup)
				rdata_ff <= rd_mux;
			if (wr && hit_ctrl)
				ctrl_ff <= pwdata[5:0];
			if (wr && hit_chain)
				chain_ff <= wr_chain;
		end
	end

	// Traffic generator, idle low when off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 5'h00;
			tx_ff  <= 1'b0;
		end else if (!ctrl_ff[CTRL_TRAFFIC]) begin
			div_ff <= 5'h00;
			tx_ff  <= 1'b0;
		end else if (div_end) begin
			div_ff <= 5'h00;
			tx_ff  <= ~tx_ff;
		end else begin
			div_ff <= div_ff + 5'h01;
		end
	end

	// Returned traffic synchroniser and edge count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sync_ff <= 3'h0;
			rx_stb_ff  <= 1'b0;
			rx_prev_ff <= 1'b0;
			cnt_ff     <= 16'h0000;
		end else begin
			rx_sync_ff <= {rx_sync_ff[1:0], link.lower_tx};
			if (rx_sync_ff[1] == rx_sync_ff[2])
				rx_stb_ff <= rx_sync_ff[2];
			rx_prev_ff <= rx_stb_ff;
			if (rx_edge)
				cnt_ff <= (wr && hit_stat) ? 16'h0001 : cnt_ff + 16'h0001;
			else if (wr && hit_stat)
				cnt_ff <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/pss_device.sv
// Purpose: device end, power sequencing, pump and supervision
// Assumes: comparators and slow oscillator arrive unsynchronised
// Notes: pclk stands in for the fast oscillator
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pss_device
	import pss_pkg::*;
#(
	parameter int          WAKE_LIMIT = WAKE_CYC,
	parameter logic [23:0] UNIT_ID    = 24'h5A3C01 // arbitrary value
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	pss_link_if.dev               link,
	input  wire logic             slow_osc,
	input  wire logic [CMP_N-1:0] cmp_raw,
	input  wire logic             pump_manual_disable,
	input  wire logic             measure_active,
	input  wire logic             diff_mode,
	input  wire logic             is_last,
	input  wire logic             forced_reset_pulldown,
	input  wire logic             soft_reset_request,
	input  wire logic             upper_receive_port,
	output logic                  upper_transmit_port,
	output logic                  regulator_en,
	output logic                  por_active,
	output logic                  osc_en,
	output logic                  pump_en,
	output logic                  logic_en,
	output logic [15:0]           diag_status_first,
	output logic [15:0]           diag_status_second,
	output logic                  shutdown_seen_alert,
	output logic [15:0]           identity_low_word,
	output logic [7:0]            identity_high_byte,
	output logic [1:0]            link_rate,
	output logic                  rate_locked
);
	localparam int NIN  = CMP_N + 4;
	localparam int I_SO = CMP_N;
	localparam int I_RX = CMP_N + 1;
	localparam int I_SD = CMP_N + 2;
	localparam int I_UR = CMP_N + 3;

	pss_state_t  state_ff;
	pss_state_t  nxt_state;
	logic [NIN-1:0] s1_ff;
	logic [NIN-1:0] s2_ff;
	logic [NIN-1:0] s3_ff;
	logic [NIN-1:0] stb_ff;
	logic [NIN-1:0] raw;
	logic        rx_prev_ff;
	logic        sd_prev_ff;
	logic        so_prev_ff;
	logic [13:0] wake_ff;
	logic [10:0] hold_ff;
	logic        run_ff;
	logic        force_ff;
	logic [10:0] osc_cnt_ff;
	logic        osc_half_ff;
	logic        osc_bad_ff;
	logic        osc_arm_ff;
	logic [5:0]  len_ff;
	logic        up_tx_ff;
	logic        dn_tx_ff;
	logic        sd_hi;
	logic        vaa_ok;
	logic        rx_edge;
	logic        rx_rise;
	logic        so_rise;
	logic        sd_fall;
	logic        clr;
	logic        pump_phase;
	logic        pump_ok;
	logic        wake_done;
	logic        osc_sample;
	logic        osc_out;
	logic [1:0]  rate_class;

	// Comparator, slow oscillator and link levels pass three flops
	assign raw = {upper_receive_port, link.sd_level, link.lower_rx,
		slow_osc, cmp_raw};
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_ff[gi]  <= 1'b0;
					s2_ff[gi]  <= 1'b0;
					s3_ff[gi]  <= 1'b0;
					stb_ff[gi] <= 1'b0;
				end else begin
					s1_ff[gi] <= raw[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi])
						stb_ff[gi] <= s3_ff[gi];
				end
			end
		end
	endgenerate

	// Qualified levels and edges
	assign sd_hi   = stb_ff[I_SD];
	assign vaa_ok  = stb_ff[CMP_VAA_OK];
	assign rx_edge = stb_ff[I_RX] ^ rx_prev_ff;
	assign rx_rise = stb_ff[I_RX] & ~rx_prev_ff;
	assign so_rise = stb_ff[I_SO] & ~so_prev_ff;
	assign sd_fall = ~sd_hi & sd_prev_ff;
	assign wake_done = wake_ff >= 14'(WAKE_LIMIT);
	// Register clear on supply loss or soft reset
	assign clr = (state_ff == ST_DRAIN && !vaa_ok) ||
		(soft_reset_request && state_ff != ST_OFF);

	// Power sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: begin
				if (sd_hi)
					nxt_state = ST_REG;
			end
			ST_REG: begin
				if (!sd_hi)
					nxt_state = ST_DRAIN;
				else if (vaa_ok)
					nxt_state = ST_OSC;
			end
			ST_OSC: begin
				nxt_state = sd_hi ? ST_PUMP : ST_DRAIN;
			end
			ST_PUMP: begin
				if (!sd_hi)
					nxt_state = ST_DRAIN;
				else if (stb_ff[CMP_AT_REG] || wake_done)
					nxt_state = ST_READY;
			end
			ST_READY: begin
				if (!sd_hi)
					nxt_state = ST_DRAIN;
				else if (soft_reset_request)
					nxt_state = ST_PUMP;
			end
			ST_DRAIN: begin
				if (!vaa_ok)
					nxt_state = ST_OFF;
			end
			default: nxt_state = ST_OFF;
		endcase
	end

	// State decodes
	assign regulator_en = state_ff != ST_OFF && state_ff != ST_DRAIN;
	assign por_active   = state_ff == ST_OFF || state_ff == ST_REG;
	assign osc_en       = regulator_en && state_ff != ST_REG;
	assign logic_en     = state_ff == ST_READY;
	assign pump_phase   = state_ff == ST_PUMP || state_ff == ST_READY;
	assign pump_ok = pump_phase && !measure_active && !pump_manual_disable
		&& !stb_ff[CMP_HVOV];
	assign pump_en      = pump_ok && run_ff;

	// Shutdown pin: wake pump drives high, pulldown drives low
	assign link.dev_sd_oe  = force_ff || hold_ff != 11'h000;
	assign link.dev_sd_out = !force_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff   <= ST_OFF;
			rx_prev_ff <= 1'b0;
			sd_prev_ff <= 1'b0;
			so_prev_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			rx_prev_ff <= stb_ff[I_RX];
			sd_prev_ff <= sd_hi;
			so_prev_ff <= stb_ff[I_SO];
		end
	end

	// Wake timer, wake pump hold, forced pulldown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_ff  <= 14'h0000;
			hold_ff  <= 11'h000;
			force_ff <= 1'b0;
		end else begin
			if (state_ff == ST_READY || state_ff == ST_DRAIN)
				wake_ff <= 14'h0000;
			else if ((state_ff == ST_OFF && rx_edge) || wake_ff != 14'h0000)
				wake_ff <= wake_done ? wake_ff : wake_ff + 14'h0001;
			if (force_ff)
				hold_ff <= 11'h000;
			else if (diff_mode && rx_edge)
				hold_ff <= 11'(PUMP_HOLD_CYC);
			else if (hold_ff != 11'h000)
				hold_ff <= hold_ff - 11'h001;
			if (forced_reset_pulldown && state_ff != ST_OFF)
				force_ff <= 1'b1;
			else if (state_ff == ST_OFF)
				force_ff <= 1'b0;
		end
	end

	// Pump hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_ff <= 1'b1;
		else if (stb_ff[CMP_AT_REG])
			run_ff <= 1'b0;
		else if (stb_ff[CMP_LOW_HYST])
			run_ff <= 1'b1;
	end

	// Slow oscillator check over two slow periods
	// Fast clock drift has no alert; decoder errors reveal it
	// First window starts at enable, not at an edge; it only arms
	assign osc_sample = so_rise && osc_half_ff;
	assign osc_out = osc_cnt_ff < 11'(OSC_EXP - OSC_TOL) ||
		osc_cnt_ff > 11'(OSC_EXP + OSC_TOL);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt_ff  <= 11'h000;
			osc_half_ff <= 1'b0;
			osc_bad_ff  <= 1'b0;
			osc_arm_ff  <= 1'b0;
		end else if (!osc_en) begin
			osc_cnt_ff  <= 11'h000;
			osc_half_ff <= 1'b0;
			osc_bad_ff  <= 1'b0;
			osc_arm_ff  <= 1'b0;
		end else begin
			if (so_rise)
				osc_half_ff <= ~osc_half_ff;
			if (osc_sample)
				osc_arm_ff <= 1'b1;
			if (osc_sample || osc_cnt_ff == 11'h7FF)
				osc_cnt_ff <= 11'h000;
			else
				osc_cnt_ff <= osc_cnt_ff + 11'h001;
			osc_bad_ff <= (osc_sample && osc_arm_ff && osc_out) ||
				osc_cnt_ff == 11'h7FF;
		end
	end

	// Sticky alerts, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_status_first   <= DS_RST;
			diag_status_second  <= DS_RST;
			shutdown_seen_alert <= 1'b0;
		end else begin
			diag_status_first[DS1_HVUV_BIT] <= (pump_phase &&
				stb_ff[CMP_HVUV]) || (diag_status_first[DS1_HVUV_BIT]
				&& !clr);
			diag_status_first[DS1_OSCA_BIT] <= osc_bad_ff ||
				(diag_status_first[DS1_OSCA_BIT] && !clr);
			diag_status_first[DS1_OSCB_BIT] <= osc_bad_ff ||
				(diag_status_first[DS1_OSCB_BIT] && !clr);
			diag_status_second[DS2_HVOV_BIT] <= stb_ff[CMP_HVOV] ||
				(diag_status_second[DS2_HVOV_BIT] && !clr);
			diag_status_second[DS2_HDRM_BIT] <= (measure_active &&
				stb_ff[CMP_HDRM]) || (diag_status_second[DS2_HDRM_BIT]
				&& !clr);
			shutdown_seen_alert <= (sd_fall && state_ff != ST_OFF) ||
				(shutdown_seen_alert && !soft_reset_request);
		end
	end

	// Rate from first low pulse after reset
	assign rate_class = (len_ff <= 6'((BIT_2M_CYC + BIT_1M_CYC) / 2)) ?
		RATE_2M : (len_ff <= 6'((BIT_1M_CYC + BIT_05M_CYC) / 2)) ?
		RATE_1M : RATE_05M;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_ff      <= 6'h00;
			link_rate   <= RATE_2M;
			rate_locked <= 1'b0;
		end else if (clr || state_ff == ST_OFF) begin
			len_ff      <= 6'h00;
			rate_locked <= 1'b0;
		end else if (!rate_locked) begin
			if (!stb_ff[I_RX] && rx_prev_ff)
				len_ff <= 6'h01; // Whole low pulses only
			else if (!stb_ff[I_RX] && len_ff != 6'h00 && len_ff != 6'h3F)
				len_ff <= len_ff + 6'h01;
			if (rx_rise && len_ff != 6'h00) begin
				link_rate   <= rate_class;
				rate_locked <= 1'b1;
			end
		end
	end

	// Chain forwarding, idle low until rate known
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_tx_ff <= 1'b0;
			dn_tx_ff <= 1'b0;
		end else begin
			up_tx_ff <= rate_locked && stb_ff[I_RX];
			dn_tx_ff <= rate_locked && (is_last ? up_tx_ff :
				stb_ff[I_UR]);
		end
	end
	assign upper_transmit_port = up_tx_ff;
	assign link.lower_tx       = dn_tx_ff;

	// Identity split over two words
	assign identity_low_word  = UNIT_ID[15:0];
	assign identity_high_byte = UNIT_ID[23:16];
endmodule
`default_nettype wire

// >>> tb/pss_assertions.sv
// Purpose: link and sequencing checks beside the link
// Assumes: one clock, pin sync adds three edges
// Notes: sees link signals, some device inputs and device outputs only
`timescale 1ns/1ns
`default_nettype none
module pss_link_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic lower_rx,
	input wire logic lower_tx,
	input wire logic dev_sd_out,
	input wire logic dev_sd_oe,
	input wire logic sd_level,
	input wire logic diff_mode,
	input wire logic is_last,
	input wire logic forced_reset_pulldown,
	input wire logic measure_active,
	input wire logic pump_manual_disable,
	input wire logic regulator_en,
	input wire logic por_active,
	input wire logic osc_en,
	input wire logic pump_en,
	input wire logic logic_en,
	input wire logic shutdown_seen_alert,
	input wire logic upper_transmit_port,
	input wire logic rate_locked
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Steps of forwarding and shutdown
	sequence s_rx_edge;
		rate_locked && $rose(lower_rx);
	endsequence
	sequence s_up_edge;
		is_last && $rose(upper_transmit_port);
	endsequence
	sequence s_sd_gone;
		$fell(sd_level) ##1 !sd_level [*6];
	endsequence

	a_pump_measure: assert property (
		measure_active |-> !pump_en) else $error("pump on while measuring");
	a_pump_manual: assert property (
		pump_manual_disable |-> !pump_en) else $error("pump on when disabled");
	a_reg_off: assert property (
		s_sd_gone |-> !regulator_en) else $error("regulator on in shutdown");
	a_sd_alert: assert property (
		$fell(regulator_en) |-> ##[0:1] shutdown_seen_alert)
		else $error("shutdown alert missing");
	a_por_holds: assert property (
		por_active |-> !osc_en && !pump_en && !logic_en)
		else $error("blocks on during reset");
	a_logic_last: assert property (
		logic_en |-> osc_en && regulator_en && !por_active)
		else $error("logic enabled too early");
	a_wake_pump: assert property (
		$changed(lower_rx) && diff_mode && !forced_reset_pulldown
		|-> ##[1:6] (dev_sd_oe && dev_sd_out)) else $error("no wake pump");
	a_force_low: assert property (
		$rose(forced_reset_pulldown) |-> ##[1:6] (dev_sd_oe && !dev_sd_out))
		else $error("no forced pulldown");
	a_fwd_up: assert property (
		s_rx_edge |-> ##[3:8] (upper_transmit_port || !rate_locked))
		else $error("upper port not forwarding");
	a_loop_down: assert property (
		s_up_edge |-> ##[1:2] (lower_tx || !rate_locked))
		else $error("loopback not sent down");
	a_tx_quiet: assert property (
		!rate_locked && !$past(rate_locked) |-> !upper_transmit_port)
		else $error("transmit before rate lock");
endmodule
`default_nettype wire

// >>> tb/tb_pss.sv
// Purpose: bench joining host end and device end
// Assumes: pclk 10 MHz, comparators and slow clock modelled here
// Notes: short wake limit keeps the run brief
`timescale 1ns/1ns
`default_nettype none
module tb_pss
	import pss_pkg::*;
;
	localparam int          TB_WAKE = 50;
	localparam logic [23:0] TB_ID   = 24'hA1B2C3; // Arbitrary value
	localparam logic [32:0] ALL     = {33{1'b1}};
	localparam logic [32:0] ERR     = {1'b1, 32'h0};
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata;
	logic             slow_osc, vaa_ok, measure_active, pump_manual_disable;
	logic             diff_mode, forced_reset_pulldown, soft_reset_request;
	logic [4:0]       cmp_lo;
	logic             upper_transmit_port, regulator_en, por_active, osc_en;
	logic             pump_en, logic_en, shutdown_seen_alert, rate_locked;
	logic [15:0]      diag_status_first, diag_status_second, identity_low_word;
	logic [7:0]       identity_high_byte;
	logic [1:0]       link_rate;
	logic [32:0]      exp_q[$], msk_q[$], m;
	logic [1:0]       rt[3] = '{RATE_2M, RATE_1M, RATE_05M};
	logic [7:0]       pt[9] = '{8'h05, 8'h01, 8'h02, 8'h00, 8'h05, 8'hA4,
		8'h44, 8'h14, 8'h09};
	int               errors, compares, n, v;
	int               seed      = 32'h187C;
	int               slow_half = 153;

	pss_link_if link();
	pss_host u_pss_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ident_value({identity_high_byte, identity_low_word}), .link(link));
	pss_device #(.WAKE_LIMIT(TB_WAKE), .UNIT_ID(TB_ID)) u_pss_device (
		.pclk(pclk), .presetn(presetn), .link(link), .slow_osc(slow_osc),
		.cmp_raw({vaa_ok, cmp_lo}), .pump_manual_disable(pump_manual_disable),
		.measure_active(measure_active), .diff_mode(diff_mode), .is_last(1'b1),
		.forced_reset_pulldown(forced_reset_pulldown),
		.soft_reset_request(soft_reset_request), .upper_receive_port(1'b0),
		.upper_transmit_port(upper_transmit_port), .regulator_en(regulator_en),
		.por_active(por_active), .osc_en(osc_en), .pump_en(pump_en),
		.logic_en(logic_en), .diag_status_first(diag_status_first),
		.diag_status_second(diag_status_second),
		.shutdown_seen_alert(shutdown_seen_alert),
		.identity_low_word(identity_low_word),
		.identity_high_byte(identity_high_byte), .link_rate(link_rate),
		.rate_locked(rate_locked));
	pss_link_checker u_pss_link_checker (.pclk(pclk), .presetn(presetn),
		.lower_rx(link.lower_rx), .lower_tx(link.lower_tx),
		.dev_sd_out(link.dev_sd_out), .dev_sd_oe(link.dev_sd_oe),
		.sd_level(link.sd_level), .diff_mode(diff_mode), .is_last(1'b1),
		.forced_reset_pulldown(forced_reset_pulldown),
		.measure_active(measure_active),
		.pump_manual_disable(pump_manual_disable), .regulator_en(regulator_en),
		.por_active(por_active), .osc_en(osc_en), .pump_en(pump_en),
		.logic_en(logic_en), .shutdown_seen_alert(shutdown_seen_alert),
		.upper_transmit_port(upper_transmit_port), .rate_locked(rate_locked));

	// Clock, slow oscillator and supply model
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		slow_osc = 1'b0;
		forever begin
			repeat (slow_half) @(posedge pclk);
			slow_osc <= ~slow_osc;
		end
	end
	always @(posedge pclk) vaa_ok <= regulator_en;

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One APB transfer, expectation noted at setup
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] e, input logic [32:0] k);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		exp_q.push_back(e);
		msk_q.push_back(k);
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1); // Only the watchdog ends a hang
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, ERR);
	endtask

	// Bus watcher takes the oldest note per completed transfer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
			m = msk_q.pop_front();
			check({pslverr, pwrite ? 32'h0 : prdata} & m, exp_q.pop_front() & m);
		end
	end

	initial begin
		repeat (40000) @(posedge pclk);
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, measure_active} = 5'h0;
		{pump_manual_disable, diff_mode, forced_reset_pulldown} = 3'h0;
		{soft_reset_request, cmp_lo, paddr, pwdata} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0, 33'h0, ALL);
		apb(1'b0, REG_CHAIN, 32'h0, {27'h0, CHAIN_RST}, ALL);
		apb(1'b0, REG_STAT, 32'h0, 33'h1 << STAT_IDV, 33'h3 << STAT_IDV);
		apb(1'b0, 12'h00C, 32'h0, ERR, ALL);
		apb(1'b1, 12'h00C, 32'hFFFF_FFFF, ERR, ALL);
		wr(REG_CHAIN, 32'h28);
		apb(1'b0, REG_CHAIN, 32'h0, 33'h20, ALL);
		v = $unsigned($random(seed)) % 33;
		wr(REG_CHAIN, 32'(v));
		apb(1'b0, REG_CHAIN, 32'h0, 33'(v), ALL);
		check({identity_high_byte, identity_low_word}, TB_ID);
		// Wake from traffic alone
		diff_mode <= 1'b1;
		wr(REG_CTRL, 32'h1);
		for (n = 0; n < TB_WAKE + 60 && logic_en !== 1'b1; n++) @(posedge pclk);
		check(logic_en, 1'b1);
		apb(1'b0, REG_STAT, 32'h0, 33'h3 << STAT_IDV, 33'h3 << STAT_IDV);
		// Each rate relocked after soft reset
		for (int r = 0; r < 3; r++) begin
			wr(REG_CTRL, 32'h1 | (32'(rt[r]) << CTRL_RATE));
			soft_reset_request <= 1'b1;
			@(posedge pclk);
			soft_reset_request <= 1'b0;
			repeat (200) @(posedge pclk);
			check(link_rate, rt[r]);
			check(rate_locked, 1'b1);
			check(regulator_en, 1'b1);
		end
		check(diag_status_first, 16'h0);
		// Pump control table
		foreach (pt[i]) begin
			{measure_active, pump_manual_disable, cmp_lo} <= pt[i][7:1];
			repeat (8) @(posedge pclk);
			check(pump_en, pt[i][0]);
		end
		cmp_lo <= 5'h0;
		check(diag_status_second, (16'h1 << DS2_HVOV_BIT) | (16'h1 << DS2_HDRM_BIT));
		check(diag_status_first, 16'h1 << DS1_HVUV_BIT);
		// Slow oscillator out of tolerance
		slow_half = 175;
		repeat (2500) @(posedge pclk);
		check(diag_status_first, (16'h1 << DS1_HVUV_BIT) | (16'h1 << DS1_OSCA_BIT)
			| (16'h1 << DS1_OSCB_BIT));
		// Idle decay: awake until the wake pump hold runs out
		wr(REG_CTRL, 32'h0);
		repeat (PUMP_HOLD_CYC - 100) @(posedge pclk);
		check(regulator_en, 1'b1);
		repeat (200) @(posedge pclk);
		check(por_active, 1'b1);
		check(shutdown_seen_alert, 1'b1);
		// Wake again, then forced shutdown as traffic stops
		wr(REG_CTRL, 32'h1);
		for (n = 0; n < TB_WAKE + 60 && logic_en !== 1'b1; n++) @(posedge pclk);
		check(logic_en, 1'b1);
		wr(REG_CTRL, 32'h0);
		forced_reset_pulldown <= 1'b1;
		@(posedge pclk);
		forced_reset_pulldown <= 1'b0;
		for (n = 0; n < 30 && regulator_en !== 1'b0; n++) @(posedge pclk);
		check(regulator_en, 1'b0);
		for (n = 0; n < 30 && por_active !== 1'b1; n++) @(posedge pclk);
		check(por_active, 1'b1);
		check(pump_en, 1'b0);
		// Single-ended: host drives shutdown input
		diff_mode <= 1'b0;
		wr(REG_CTRL, (32'h1 << CTRL_SE) | (32'h1 << CTRL_SD_LVL));
		for (n = 0; n < 30 && regulator_en !== 1'b1; n++) @(posedge pclk);
		check(regulator_en, 1'b1);
		wr(REG_CTRL, 32'h1 << CTRL_SE);
		for (n = 0; n < 30 && regulator_en !== 1'b0; n++) @(posedge pclk);
		check(regulator_en, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
